// file: shared/adcsq_regs.svh
// Register offsets, field positions, reset values and timing counts for the converter sequencer.
// Assumes a classic Wishbone slave with 32-bit data, one aligned word per register.
`ifndef ADCSQ_REGS_SVH
`define ADCSQ_REGS_SVH

`define ADCSQ_OFF_PER_EN 8'h00
`define ADCSQ_OFF_MODE0 8'h04
`define ADCSQ_OFF_MODE1 8'h08
`define ADCSQ_OFF_MODE2 8'h0c
`define ADCSQ_OFF_UPPER 8'h10
`define ADCSQ_OFF_LOWER 8'h14
`define ADCSQ_OFF_CHSEL 8'h18
`define ADCSQ_OFF_IRQF 8'h1c
`define ADCSQ_OFF_IRQM 8'h20
`define ADCSQ_OFF_RESULT 8'h24
`define ADCSQ_OFF_STATUS 8'h28

`define ADCSQ_PER_CLKGATE 5
`define ADCSQ_M0_RUN 7
`define ADCSQ_M0_SCAN 6
`define ADCSQ_M0_DIV_LO 3
`define ADCSQ_M0_VMODE_LO 1
`define ADCSQ_M0_CMPEN 0
`define ADCSQ_M1_TMODE_LO 6
`define ADCSQ_M1_ONESHOT 5
`define ADCSQ_M1_TSRC_LO 0
`define ADCSQ_M2_PREF_LO 6
`define ADCSQ_M2_NREF 5
`define ADCSQ_M2_LIMSEL 3
`define ADCSQ_M2_SNOOZE 2
`define ADCSQ_M2_RES8 0
`define ADCSQ_CH_INTSRC 7

`define ADCSQ_RST_ZERO 8'h00
`define ADCSQ_RST_UPPER 8'hff
`define ADCSQ_RST_MASK 8'h01

// Conversion takes this many conversion-clock ticks (sampling, one idle tick, then ten bit steps)
`define ADCSQ_CONV_TICKS 5'h0c

`endif

// file: shared/adcsq_pkg.sv
// Types shared by the converter sequencer: modes, states and carried bundles.
// Assumes the register header supplies all numeric offsets and fields.
package adcsq_pkg;

    typedef enum logic [1:0] {
        ADCSQ_TRG_SW0,
        ADCSQ_TRG_SW1,
        ADCSQ_TRG_HW_NOWAIT,
        ADCSQ_TRG_HW_WAIT
    } adcsq_trig_e;

    typedef enum {
        ADCSQ_IDLE,
        ADCSQ_STAB,
        ADCSQ_WAIT_TRG,
        ADCSQ_CONVERT
    } adcsq_state_e;

    // Analog-side control bundle presented to the comparator macro
    typedef struct packed {
        logic cmp_enable;
        logic [1:0] pos_ref;
        logic neg_ref;
        logic int_source;
        logic [4:0] channel;
        logic res8;
    } adcsq_analog_s;

    // Hardware trigger event bundle
    typedef struct packed {
        logic timer_ch01_interrupt;
        logic calendar_clock_interrupt;
        logic interval_timer_interrupt;
    } adcsq_hwtrig_s;

endpackage

// file: design/adcsq_top.sv
// Control logic of a successive-approximation converter: registers, clock gate,
// divider, trigger selection, sequencing, limit window and interrupt flag.
// Assumes the comparator macro returns one decision bit per conversion-clock tick.
// Function
// - Converter clock runs only while clock gate bit is one.
// - Scan bit zero converts selected channel, one scans channels.
// - Divider codes 000-110 give /64,/32,/16,/8,/6,/5,/4; others prohibited.
// - Hardware trigger source 00 timer, 10 calendar, 11 interval; 01 prohibited.
// - Repeat bit zero is sequential conversion, one is one-shot.
// - Trigger mode upper bit zero software; 10 hardware no-wait; 11 wait.
// - Resolution bit zero gives 10-bit results, one gives 8-bit.
// - Snooze wakeup bit one enables snooze conversion, zero leaves unused.
// - Limit select zero: interrupt when lower <= result <= upper.
// - Limit select one: interrupt when result below lower or above upper.
// - Negative reference from ground at zero, reference pin at one.
// - Positive reference 00 supply, 01 pin, 10 internal; 11 prohibited.
// - Two 8-bit limit registers hold upper and lower comparison bounds.
// - Channel codes map to inputs 0-7, 16-19, sensor, reference; else prohibited.
// - Interrupt flag reads zero when idle (here a set flag holds through idle until written zero); software clears by writing zero.
// - Interrupt flag reads one once a conversion-end request is generated.
// - Mask bit zero passes interrupt processing, one blocks it.
// - Comparator enable bit runs comparator at one, stops at zero.
// - Run bit one enables conversion, zero stops it.
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
`include "adcsq_regs.svh"

module adcsq_top (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cmp_bit_in,
    input wire adcsq_pkg::adcsq_hwtrig_s hw_trig_in,
    output logic conv_clk_out,
    output adcsq_pkg::adcsq_analog_s analog_ctrl_out,
    output logic sample_out,
    output logic conversion_end_interrupt_out,
    output logic snooze_wakeup_out
);

    logic [7:0] per_r, per_nxt, mode0_r, mode0_nxt, mode1_r, mode1_nxt, mode2_r, mode2_nxt;
    logic [7:0] upper_r, upper_nxt, lower_r, lower_nxt, chsel_r, chsel_nxt;
    logic irqf_r, irqf_nxt, mask_r, mask_nxt;
    logic [15:0] result_r, result_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic ack_r, ack_nxt;
    logic [5:0] div_cnt_r, div_cnt_nxt;
    logic tick_r, tick_nxt;
    logic cclk_r, cclk_nxt;
    adcsq_pkg::adcsq_state_e state_r, state_nxt;
    logic [4:0] step_r, step_nxt;
    logic [9:0] sar_r, sar_nxt;
    logic sample_r, sample_nxt;
    logic irq_out_r, irq_out_nxt;
    adcsq_pkg::adcsq_analog_s ana_r, ana_nxt;
    logic prohibited_r, prohibited_nxt;
    logic done_r, done_nxt;

    logic wr, rd_cyc;
    logic hw_event;
    logic in_window, fire;
    logic [9:0] res_cmp;

    // Conversion clock divisor from divider code; zero marks a prohibited code
    function automatic logic [6:0] div_of(input logic [2:0] code);
        unique case (code)
            3'h0: div_of = 7'h40;
            3'h1: div_of = 7'h20;
            3'h2: div_of = 7'h10;
            3'h3: div_of = 7'h08;
            3'h4: div_of = 7'h06;
            3'h5: div_of = 7'h05;
            3'h6: div_of = 7'h04;
            3'h7: div_of = 7'h00;
        endcase
    endfunction

    // Legal channel codes only; others stall conversion rather than sample garbage
    function automatic logic chan_ok(input logic [7:0] cs);
        if (cs[`ADCSQ_CH_INTSRC]) begin
            chan_ok = (cs[6:1] == 6'h00);
        end else begin
            chan_ok = (cs[6:3] == 4'h0) || (cs[6:2] == 5'h04);
        end
    endfunction

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
    assign rd_cyc = wb_cyc_i && wb_stb_i && !ack_r;

    // Register file writes, flag set and clear
    always_comb begin
        per_nxt = per_r;
        mode0_nxt = mode0_r;
        mode1_nxt = mode1_r;
        mode2_nxt = mode2_r;
        upper_nxt = upper_r;
        lower_nxt = lower_r;
        chsel_nxt = chsel_r;
        irqf_nxt = irqf_r;
        mask_nxt = mask_r;
        if (wr && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                `ADCSQ_OFF_PER_EN: per_nxt = wb_dat_i[7:0];
                `ADCSQ_OFF_MODE0: mode0_nxt = wb_dat_i[7:0];
                `ADCSQ_OFF_MODE1: mode1_nxt = wb_dat_i[7:0] & 8'he3;
                `ADCSQ_OFF_MODE2: mode2_nxt = wb_dat_i[7:0] & 8'hed;
                `ADCSQ_OFF_UPPER: upper_nxt = wb_dat_i[7:0];
                `ADCSQ_OFF_LOWER: lower_nxt = wb_dat_i[7:0];
                `ADCSQ_OFF_CHSEL: chsel_nxt = wb_dat_i[7:0] & 8'h9f;
                `ADCSQ_OFF_IRQF: irqf_nxt = irqf_r & wb_dat_i[0];
                `ADCSQ_OFF_IRQM: mask_nxt = wb_dat_i[0];
                default: ;
            endcase
        end
        // Set beats a clear landing in the same cycle
        if (fire) begin
            irqf_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            per_r <= `ADCSQ_RST_ZERO;
            mode0_r <= `ADCSQ_RST_ZERO;
            mode1_r <= `ADCSQ_RST_ZERO;
            mode2_r <= `ADCSQ_RST_ZERO;
            upper_r <= `ADCSQ_RST_UPPER;
            lower_r <= `ADCSQ_RST_ZERO;
            chsel_r <= `ADCSQ_RST_ZERO;
            irqf_r <= 1'b0;
            mask_r <= 1'b1;
        end else begin
            per_r <= per_nxt;
            mode0_r <= mode0_nxt;
            mode1_r <= mode1_nxt;
            mode2_r <= mode2_nxt;
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
            chsel_r <= chsel_nxt;
            irqf_r <= irqf_nxt;
            mask_r <= mask_nxt;
        end
    end

    // Bus answer: one wait-free cycle, unmapped reads return zero
    always_comb begin
        ack_nxt = rd_cyc;
        rdat_nxt = rdat_r;
        if (rd_cyc) begin
            unique case (wb_adr_i)
                `ADCSQ_OFF_PER_EN: rdat_nxt = {24'h000000, per_r};
                `ADCSQ_OFF_MODE0: rdat_nxt = {24'h000000, mode0_r};
                `ADCSQ_OFF_MODE1: rdat_nxt = {24'h000000, mode1_r};
                `ADCSQ_OFF_MODE2: rdat_nxt = {24'h000000, mode2_r};
                `ADCSQ_OFF_UPPER: rdat_nxt = {24'h000000, upper_r};
                `ADCSQ_OFF_LOWER: rdat_nxt = {24'h000000, lower_r};
                `ADCSQ_OFF_CHSEL: rdat_nxt = {24'h000000, chsel_r};
                `ADCSQ_OFF_IRQF: rdat_nxt = {31'h0, irqf_r};
                `ADCSQ_OFF_IRQM: rdat_nxt = {31'h0, mask_r};
                `ADCSQ_OFF_RESULT: rdat_nxt = {16'h0000, result_r};
                `ADCSQ_OFF_STATUS: rdat_nxt = {29'h0, prohibited_r,
                                               state_r == adcsq_pkg::ADCSQ_CONVERT,
                                               state_r != adcsq_pkg::ADCSQ_IDLE};
                default: rdat_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h00000000;
        end else begin
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // Divider: runs only with the clock gate open and a legal standard mode
    always_comb begin
        logic [6:0] dv;
        dv = div_of(mode0_r[`ADCSQ_M0_DIV_LO +: 3]);
        prohibited_nxt = (dv == 7'h00) || mode0_r[`ADCSQ_M0_VMODE_LO + 1]
                         || (mode1_r[1:0] == 2'h1)
                         || (mode2_r[7:6] == 2'h3)
                         || !chan_ok(chsel_r);
        div_cnt_nxt = 6'h00;
        tick_nxt = 1'b0;
        cclk_nxt = 1'b0;
        if (per_r[`ADCSQ_PER_CLKGATE] && !prohibited_r) begin
            if ({1'b0, div_cnt_r} == dv - 7'h01) begin
                tick_nxt = 1'b1;
            end else begin
                div_cnt_nxt = div_cnt_r + 6'h01;
            end
            cclk_nxt = ({1'b0, div_cnt_r} < (dv >> 1));
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            div_cnt_r <= 6'h00;
            tick_r <= 1'b0;
            cclk_r <= 1'b0;
            prohibited_r <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            tick_r <= tick_nxt;
            cclk_r <= cclk_nxt;
            prohibited_r <= prohibited_nxt;
        end
    end

    // Hardware trigger routing by source code
    always_comb begin
        unique case (mode1_r[`ADCSQ_M1_TSRC_LO +: 2])
            2'h0: hw_event = hw_trig_in.timer_ch01_interrupt;
            2'h2: hw_event = hw_trig_in.calendar_clock_interrupt;
            2'h3: hw_event = hw_trig_in.interval_timer_interrupt;
            default: hw_event = 1'b0;
        endcase
    end

    // Limit window check on the upper eight result bits
    assign res_cmp = sar_r;
    assign in_window = (res_cmp[9:2] >= lower_r) && (res_cmp[9:2] <= upper_r);
    assign fire = (state_r == adcsq_pkg::ADCSQ_CONVERT) && tick_r && (step_r == 5'h00)
                  && (mode2_r[`ADCSQ_M2_LIMSEL] ? ((res_cmp[9:2] < lower_r)
                  || (res_cmp[9:2] > upper_r)) : in_window);

    // Sequencer: waits for trigger, samples, resolves bits, stores, repeats or stops
    always_comb begin
        logic run, hw_mode;
        logic [4:0] stop_bits;
        run = mode0_r[`ADCSQ_M0_RUN] && mode0_r[`ADCSQ_M0_CMPEN] && !prohibited_r;
        hw_mode = mode1_r[`ADCSQ_M1_TMODE_LO + 1];
        stop_bits = mode2_r[`ADCSQ_M2_RES8] ? 5'h02 : 5'h00;
        state_nxt = state_r;
        step_nxt = step_r;
        sar_nxt = sar_r;
        result_nxt = result_r;
        sample_nxt = 1'b0;
        // A finished one-shot parks in idle until run drops or the one-shot bit clears
        done_nxt = done_r && run && mode1_r[`ADCSQ_M1_ONESHOT];
        if (!run) begin
            state_nxt = adcsq_pkg::ADCSQ_IDLE;
        end else begin
            unique case (state_r)
                adcsq_pkg::ADCSQ_IDLE: begin
                    // Wait mode skips the stabilization tick and waits for the trigger at once
                    if (!done_r) begin
                        state_nxt = (hw_mode && mode1_r[`ADCSQ_M1_TMODE_LO]) ?
                                    adcsq_pkg::ADCSQ_WAIT_TRG : adcsq_pkg::ADCSQ_STAB;
                    end
                end
                adcsq_pkg::ADCSQ_STAB: begin
                    if (tick_r) begin
                        state_nxt = hw_mode ? adcsq_pkg::ADCSQ_WAIT_TRG
                                            : adcsq_pkg::ADCSQ_CONVERT;
                        step_nxt = `ADCSQ_CONV_TICKS - 5'h01;
                    end
                end
                adcsq_pkg::ADCSQ_WAIT_TRG: begin
                    if (hw_event) begin
                        state_nxt = adcsq_pkg::ADCSQ_CONVERT;
                        step_nxt = `ADCSQ_CONV_TICKS - 5'h01;
                    end
                end
                adcsq_pkg::ADCSQ_CONVERT: begin
                    if (tick_r) begin
                        if (step_r == `ADCSQ_CONV_TICKS - 5'h01) begin
                            sample_nxt = 1'b1;
                            sar_nxt = 10'h000;
                        end else if (step_r >= stop_bits && step_r < 5'h0a) begin
                            sar_nxt[step_r[3:0]] = cmp_bit_in;
                        end
                        if (step_r == 5'h00) begin
                            result_nxt = mode2_r[`ADCSQ_M2_RES8] ? {sar_r[9:2], 8'h00}
                                                                 : {sar_r[9:1], cmp_bit_in,
                                                                    6'h00};
                            step_nxt = `ADCSQ_CONV_TICKS - 5'h01;
                            if (mode1_r[`ADCSQ_M1_ONESHOT]) begin
                                state_nxt = adcsq_pkg::ADCSQ_IDLE;
                                done_nxt = 1'b1;
                            end else if (hw_mode) begin
                                state_nxt = adcsq_pkg::ADCSQ_WAIT_TRG;
                            end
                        end else begin
                            step_nxt = step_r - 5'h01;
                        end
                    end
                end
            endcase
        end
        // Channel scanning walks upward from the selected code to the end of its group of four, then restarts
        ana_nxt.cmp_enable = mode0_r[`ADCSQ_M0_CMPEN];
        ana_nxt.pos_ref = mode2_r[`ADCSQ_M2_PREF_LO +: 2];
        ana_nxt.neg_ref = mode2_r[`ADCSQ_M2_NREF];
        ana_nxt.int_source = chsel_r[`ADCSQ_CH_INTSRC];
        ana_nxt.channel = (mode0_r[`ADCSQ_M0_SCAN] && !chsel_r[`ADCSQ_CH_INTSRC]) ?
                          ana_r.channel : chsel_r[4:0];
        if (mode0_r[`ADCSQ_M0_SCAN] && fire_or_end(state_r, tick_r, step_r)) begin
            ana_nxt.channel = (ana_r.channel[1:0] == 2'h3) ? chsel_r[4:0]
                              : ana_r.channel + 5'h01;
        end
        ana_nxt.res8 = mode2_r[`ADCSQ_M2_RES8];
        irq_out_nxt = irqf_r && !mask_r;
    end

    // True at the tick that ends a conversion
    function automatic logic fire_or_end(input adcsq_pkg::adcsq_state_e st,
                                         input logic tk, input logic [4:0] sp);
        fire_or_end = (st == adcsq_pkg::ADCSQ_CONVERT) && tk && (sp == 5'h00);
    endfunction

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_r <= adcsq_pkg::ADCSQ_IDLE;
            step_r <= 5'h00;
            sar_r <= 10'h000;
            result_r <= 16'h0000;
            sample_r <= 1'b0;
            ana_r <= '0;
            irq_out_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            step_r <= step_nxt;
            sar_r <= sar_nxt;
            result_r <= result_nxt;
            sample_r <= sample_nxt;
            ana_r <= ana_nxt;
            irq_out_r <= irq_out_nxt;
            done_r <= done_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;
    assign conv_clk_out = cclk_r;
    assign analog_ctrl_out = ana_r;
    assign sample_out = sample_r;
    assign conversion_end_interrupt_out = irq_out_r;
    assign snooze_wakeup_out = mode2_r[`ADCSQ_M2_SNOOZE];

endmodule

// file: bench/adcsq_properties.sv
// Port-level checks on the converter sequencer, with shadow copies of a few registers.
// Assumes the register map of adcsq_regs.svh and a master that waits for ack.
`timescale 1ns/100ps
`include "adcsq_regs.svh"
module adcsq_properties (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic conv_clk_out,
    input wire adcsq_pkg::adcsq_analog_s analog_ctrl_out,
    input wire logic sample_out,
    input wire logic snooze_wakeup_out
);
    logic req;
    logic wr;
    logic [7:0] per_r, per_nxt, m0_r, m0_nxt, m2_r, m2_nxt, up_r, up_nxt;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];

    // Shadow registers follow bus writes so outputs can be tied to their cause
    always_comb begin
        per_nxt = (wr && wb_adr_i == `ADCSQ_OFF_PER_EN) ? wb_dat_i[7:0] : per_r;
        m0_nxt = (wr && wb_adr_i == `ADCSQ_OFF_MODE0) ? wb_dat_i[7:0] : m0_r;
        m2_nxt = (wr && wb_adr_i == `ADCSQ_OFF_MODE2) ? wb_dat_i[7:0] : m2_r;
        up_nxt = (wr && wb_adr_i == `ADCSQ_OFF_UPPER) ? wb_dat_i[7:0] : up_r;
    end
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            per_r <= 8'h00;
            m0_r <= 8'h00;
            m2_r <= 8'h00;
            up_r <= 8'hff;
        end else begin
            per_r <= per_nxt;
            m0_r <= m0_nxt;
            m2_r <= m2_nxt;
            up_r <= up_nxt;
        end
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    a_ack_one_cycle: assert property (req |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_gate_stops_clk: assert property (!per_r[5] [*3] |-> !conv_clk_out)
        else $error("conversion clock runs with gate off");
    a_bad_div_quiet: assert property ((m0_r[5:3] == 3'h7) [*3] |-> !conv_clk_out)
        else $error("conversion clock runs on prohibited divider");
    // Stable forms allow one cycle of output registering after a write
    a_snooze_level: assert property ($stable(m2_r) |-> snooze_wakeup_out == m2_r[2])
        else $error("snooze output differs from its bit");
    a_res8_follow: assert property ($stable(m2_r) |-> analog_ctrl_out.res8 == m2_r[0])
        else $error("resolution output differs from its bit");
    a_negref_follow: assert property ($stable(m2_r) |-> analog_ctrl_out.neg_ref == m2_r[5])
        else $error("negative reference output differs from its bit");
    a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i > 8'h28 |=> wb_dat_o == 32'h0)
        else $error("unmapped read returned nonzero");
    a_limit_readback: assert property (req && !wb_we_i && wb_adr_i == `ADCSQ_OFF_UPPER
        |=> wb_dat_o == {24'h0, up_r})
        else $error("upper limit read differs from last write");

    c_sample: cover property (sample_out);
    c_bad_div: cover property (per_r[5] && m0_r[5:3] == 3'h7);
    c_snooze: cover property (snooze_wakeup_out);
endmodule

bind adcsq_top adcsq_properties adcsq_properties_i (.sys_clk_in, .rst_in, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .conv_clk_out,
    .analog_ctrl_out, .sample_out, .snooze_wakeup_out);

// file: bench/adcsq_top_tb_top.sv
// Self-checking bench for the converter sequencer: Wishbone tasks and directed tests.
// Assumes the register map of adcsq_regs.svh; comparator and triggers driven directly.
`timescale 1ns/100ps
`include "adcsq_regs.svh"
module adcsq_top_tb_top;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic cmp_bit_in = 1'b0;
    adcsq_pkg::adcsq_hwtrig_s hw_trig_in = '0;
    adcsq_pkg::adcsq_analog_s analog_ctrl_out;
    logic conv_clk_out, sample_out, conversion_end_interrupt_out, snooze_wakeup_out;
    int mismatches = 0;
    int check_count = 0;
    int ns, nc, per, i;
    logic [31:0] rd;
    logic [31:0] rst_exp [12] = '{0, 0, 0, 0, 32'hff, 0, 0, 0, 1, 0, 0, 0};
    int div_tab [7] = '{64, 32, 16, 8, 6, 5, 4};
    // Address, value and expected prohibited flag in bit 16
    logic [16:0] tab [9] = '{17'h104b5, 17'h10801, 17'h10cc0, 17'h11808, 17'h11882,
        17'h11814, 17'h01813, 17'h01881, 17'h00c80};
    logic [2:0] trg [4] = '{3'h4, 3'h2, 3'h1, 3'h4};
    logic [7:0] src [4] = '{8'ha0, 8'ha2, 8'ha3, 8'he0};

    always #25 sys_clk_in = ~sys_clk_in;

    adcsq_top adcsq_top_i (.sys_clk_in, .rst_in, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_bit_in, .hw_trig_in, .conv_clk_out,
        .analog_ctrl_out, .sample_out, .conversion_end_interrupt_out, .snooze_wakeup_out);

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held until ack is sampled high, then released for at least a cycle
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk_in);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= wd;
        repeat (20) begin
            @(posedge sys_clk_in);
            if (wb_ack_o === 1'b1) begin
                rd = wb_dat_o;
                wb_cyc_i <= 1'b0;
                wb_stb_i <= 1'b0;
                return;
            end
        end
        chk("bus ack", 1, 0);
        stop_test();
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(what, e, rd & m);
    endtask

    // Counts sample pulses and conversion clock rises over n cycles
    task automatic watch(input int n);
        logic last;
        last = conv_clk_out;
        ns = 0;
        nc = 0;
        repeat (n) begin
            @(posedge sys_clk_in);
            ns += (sample_out === 1'b1);
            nc += (conv_clk_out === 1'b1 && last === 1'b0);
            last = conv_clk_out;
        end
    endtask

    task automatic period();
        int e;
        logic last;
        last = conv_clk_out;
        e = 0;
        per = 0;
        repeat (400) begin
            @(posedge sys_clk_in);
            per += (e == 1);
            e += (conv_clk_out === 1'b1 && last === 1'b0 && e < 2);
            last = conv_clk_out;
        end
    endtask

    task automatic wait_smp(input int cnt);
        repeat (4000) begin
            @(posedge sys_clk_in);
            cnt -= (sample_out === 1'b1 && cnt > 0);
        end
        if (cnt > 0) begin
            chk("sample pulse", 1, 0);
            stop_test();
        end
    endtask

    initial begin
        repeat (5) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        for (i = 0; i < 12; i++) rchk("reset value", 8'(i * 4), '1, rst_exp[i]);
        wb(1, `ADCSQ_OFF_UPPER, 32'h5a);
        wb(1, `ADCSQ_OFF_LOWER, 32'ha5);
        rchk("upper limit", `ADCSQ_OFF_UPPER, '1, 32'h5a);
        rchk("lower limit", `ADCSQ_OFF_LOWER, '1, 32'ha5);
        wb(1, `ADCSQ_OFF_MODE2, 32'h64);
        wb(1, `ADCSQ_OFF_CHSEL, 32'h81);
        repeat (3) @(posedge sys_clk_in);
        chk("snooze", 1, snooze_wakeup_out);
        chk("neg ref", 1, analog_ctrl_out.neg_ref);
        chk("pos ref", 1, analog_ctrl_out.pos_ref);
        chk("channel", 32'h21, {analog_ctrl_out.int_source, analog_ctrl_out.channel});
        chk("cmp off", 0, analog_ctrl_out.cmp_enable);
        wb(1, `ADCSQ_OFF_MODE2, 0);
        wb(1, `ADCSQ_OFF_CHSEL, 0);
        $display("test registers done");
        wb(1, `ADCSQ_OFF_PER_EN, 32'h20);
        for (i = 0; i < 7; i++) begin
            wb(1, `ADCSQ_OFF_MODE0, {24'h0, 2'b10, 3'(i), 3'b001});
            period();
            chk("divider period", div_tab[i], per);
        end
        chk("cmp on", 1, analog_ctrl_out.cmp_enable);
        wb(1, `ADCSQ_OFF_MODE0, 32'hb9);
        watch(200);
        chk("clock at divider 111", 0, nc);
        wb(1, `ADCSQ_OFF_MODE0, 32'hb1);
        for (i = 0; i < 9; i++) begin
            wb(1, tab[i][15:8], {24'h0, tab[i][7:0]});
            rchk("prohibited", `ADCSQ_OFF_STATUS, 4, {tab[i][16], 2'h0});
            wb(1, tab[i][15:8], (tab[i][15:8] == `ADCSQ_OFF_MODE0) ? 32'hb1 : 0);
        end
        wb(1, `ADCSQ_OFF_PER_EN, 0);
        // A tick already in flight may still finish a step
        repeat (2) @(posedge sys_clk_in);
        watch(300);
        chk("clock with gate off", 0, nc + ns);
        wb(1, `ADCSQ_OFF_PER_EN, 32'h20);
        $display("test clocking done");
        wb(1, `ADCSQ_OFF_LOWER, 32'h10);
        wb(1, `ADCSQ_OFF_UPPER, 32'hff);
        wb(1, `ADCSQ_OFF_IRQF, 0);
        wait_smp(2);
        rchk("flag outside window", `ADCSQ_OFF_IRQF, 1, 0);
        wb(1, `ADCSQ_OFF_MODE2, 32'h08);
        wait_smp(2);
        rchk("flag below lower", `ADCSQ_OFF_IRQF, 1, 1);
        rchk("zero result", `ADCSQ_OFF_RESULT, '1, 0);
        wb(1, `ADCSQ_OFF_IRQM, 0);
        repeat (3) @(posedge sys_clk_in);
        chk("irq unmasked", 1, conversion_end_interrupt_out);
        wb(1, `ADCSQ_OFF_IRQM, 1);
        repeat (3) @(posedge sys_clk_in);
        chk("irq masked", 0, conversion_end_interrupt_out);
        wb(1, `ADCSQ_OFF_MODE0, 32'h31);
        watch(200);
        chk("samples when stopped", 0, ns);
        wb(1, `ADCSQ_OFF_IRQF, 0);
        rchk("flag cleared", `ADCSQ_OFF_IRQF, 1, 0);
        cmp_bit_in <= 1'b1;
        wb(1, `ADCSQ_OFF_LOWER, 0);
        wb(1, `ADCSQ_OFF_MODE2, 0);
        wb(1, `ADCSQ_OFF_MODE0, 32'hb1);
        wait_smp(2);
        rchk("10-bit result", `ADCSQ_OFF_RESULT, '1, 32'hffc0);
        rchk("flag inside window", `ADCSQ_OFF_IRQF, 1, 1);
        wb(1, `ADCSQ_OFF_MODE2, 1);
        wait_smp(2);
        rchk("8-bit result", `ADCSQ_OFF_RESULT, '1, 32'hff00);
        // Scan steps one channel per conversion of 12 ticks at divide by 4
        wb(1, `ADCSQ_OFF_MODE0, 32'hf1);
        wait_smp(1);
        rd = analog_ctrl_out.channel;
        repeat (48) @(posedge sys_clk_in);
        chk("scan channel", (rd + 1) & 3, analog_ctrl_out.channel);
        $display("test conversion done");
        wb(1, `ADCSQ_OFF_MODE0, 32'h31);
        wb(1, `ADCSQ_OFF_MODE1, 32'h20);
        wb(1, `ADCSQ_OFF_MODE0, 32'hb1);
        wait_smp(1);
        watch(300);
        chk("one-shot repeats", 0, ns);
        for (i = 0; i < 4; i++) begin
            wb(1, `ADCSQ_OFF_MODE0, 32'h31);
            wb(1, `ADCSQ_OFF_MODE1, src[i]);
            wb(1, `ADCSQ_OFF_MODE0, 32'hb1);
            hw_trig_in <= 3'h7 ^ trg[i];
            @(posedge sys_clk_in);
            hw_trig_in <= '0;
            watch(100);
            chk("start on other trigger", 0, ns);
            hw_trig_in <= trg[i];
            @(posedge sys_clk_in);
            hw_trig_in <= '0;
            wait_smp(1);
        end
        $display("test triggers done");
        stop_test();
    end
endmodule
